// File: sfs_pkg.sv
// Constants, types and opcodes for the serial flash command sequencer.
// Assumes a host that drives chip select, serial clock and serial input.
package sfs_pkg;
   // Command opcodes
   localparam logic [7:0] READ_CMD = 8'h03;
   localparam logic [7:0] FAST_READ_CMD = 8'h0B;
   localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
   localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
   localparam logic [7:0] BLOCK_ERASE_CMD = 8'hD8;
   localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] READ_STATUS_CMD = 8'h05;
   // Frame positions, counted in bytes and bits
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BYTE_OPCODE = 3'h0;
   localparam logic [2:0] BYTE_ADDR_LAST = 3'h3;
   localparam logic [2:0] BYTE_DUMMY = 3'h4;
   localparam logic [2:0] BYTE_DATA = 3'h4;
   localparam logic [2:0] BYTE_SAT = 3'h5;
   // Array geometry, as address bit counts
   localparam int PAGE_AW = 8;
   localparam int SECTOR_AW = 12;
   localparam int BLOCK_AW = 16;
   localparam int HOST_AW = 24;
   localparam int BP_W = 3;
   // Status byte layout
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_LATCH_BIT = 1;
   localparam int STAT_BP_LSB = 2;
   // Reset values and fill pattern
   localparam logic [BP_W-1:0] BP_RESET = 3'h7;
   localparam logic [BP_W-1:0] BP_NONE = 3'h0;
   localparam logic [BP_W-1:0] BP_ALL = 3'h7;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [2:0] CS_SYNC_RESET = 3'h7;
   // Default self-timed durations in sys_clk cycles
   localparam int DEF_PROG_CYCLES = 64;
   localparam int DEF_SECTOR_ERASE_CYCLES = 128;
   localparam int DEF_BLOCK_ERASE_CYCLES = 256;
   // Core sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PROGRAM = 2'b01,
      ST_ERASE = 2'b10,
      ST_HOLD = 2'b11
   } sfs_state_e;
   // Output source during a frame
   typedef enum logic [1:0] {
      TX_NONE = 2'b00,
      TX_MEM = 2'b01,
      TX_STATUS = 2'b10
   } sfs_tx_e;
   // Command left behind by a frame for the core to act on
   typedef struct packed {
      logic [7:0] opcode;
      logic ok;
      logic [HOST_AW-1:0] addr;
   } sfs_desc_s;
endpackage

// File: sfs_top.sv
// Serial flash command sequencer: link front end plus self-timed core.
// Assumes spi_clk stops while chip_select_n is high and that the host
// leaves chip_select_n high for at least four sys_clk periods.
`timescale 1ns/1ps
module sfs_top #(
   parameter int ADDR_W = 18,
   parameter int PROG_CYCLES = sfs_pkg::DEF_PROG_CYCLES,
   parameter int SECTOR_ERASE_CYCLES = sfs_pkg::DEF_SECTOR_ERASE_CYCLES,
   parameter int BLOCK_ERASE_CYCLES = sfs_pkg::DEF_BLOCK_ERASE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic spi_clk,
   input wire logic chip_select_n,
   input wire logic serial_in,
   input wire logic block_protect_wr,
   input wire logic [sfs_pkg::BP_W-1:0] block_protect_val,
   output logic serial_out,
   output logic serial_out_en,
   output logic busy_flag,
   output logic write_latch,
   output logic [sfs_pkg::BP_W-1:0] block_protect
);
   import sfs_pkg::*;

   localparam int MEM_BYTES = 1 << ADDR_W;
   localparam int PAGE_BYTES = 1 << PAGE_AW;

   // Array: written by the core, read by the link while no cycle runs
   logic [7:0] mem [MEM_BYTES];
   // Page buffer: filled by the link, drained by the core
   logic [7:0] pb_data [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pb_valid; // Bytes received this command
   logic [PAGE_AW-1:0] pb_ptr; // Next page offset to fill
   logic pb_armed; // Current frame may fill the buffer
   logic pb_we;

   // Link side frame state
   logic link_rst_b; // Link reset or deselect
   logic [2:0] bit_cnt;
   logic [2:0] byte_cnt; // Saturates once data bytes start
   logic [6:0] rx_sh;
   logic [7:0] rx_byte;
   logic byte_done;
   logic [7:0] opcode;
   logic [HOST_AW-1:0] addr;
   logic [HOST_AW-1:0] next_addr;
   sfs_desc_s desc; // Survives deselect for the core
   sfs_tx_e tx_mode;
   logic [ADDR_W-1:0] tx_start;
   logic [ADDR_W-1:0] tx_addr;
   logic [6:0] tx_sh;
   logic [2:0] tx_idx;
   logic tx_started;
   logic [7:0] tx_byte;
   logic [ADDR_W-1:0] tx_fetch;

   // Status crossing into the link domain
   logic [7:0] status_word; // Core-side source flop
   logic [7:0] st_f1;
   logic [7:0] st_f2;
   logic [7:0] st_f3;
   logic [7:0] status_l; // Settled copy at the link
   logic busy_l;

   // Core side
   logic [2:0] cs_f; // Deselect synchroniser
   logic cs_lvl;
   logic cs_rise;
   sfs_state_e state;
   sfs_state_e next_state;
   logic [ADDR_W-1:0] wp; // Walk pointer
   logic [ADDR_W-1:0] wlast;
   logic [31:0] timer;
   logic start_prog;
   logic start_sector;
   logic start_block;
   logic start_any;
   logic [ADDR_W-1:0] d_addr;
   logic [ADDR_W-1:0] page_last;
   logic [ADDR_W-1:0] sector_last;
   logic [ADDR_W-1:0] block_last;
   logic mem_we;
   logic [7:0] mem_wdata;

   // Lowest address of the protected area against a target's last byte
   function automatic logic is_protected(input logic [BP_W-1:0] bp,
                                         input logic [ADDR_W-1:0] last);
      int sh;
      logic [ADDR_W:0] size;
      logic [ADDR_W:0] top;
      sh = BLOCK_AW + int'(bp) - 1;
      top = (ADDR_W+1)'(MEM_BYTES);
      size = '0;
      if (bp == BP_NONE) begin
         return 1'b0;
      end
      if (bp == BP_ALL || sh >= ADDR_W) begin
         return 1'b1;
      end
      size = (ADDR_W+1)'(1) << sh;
      return {1'b0, last} >= (top - size);
   endfunction

   // Deselect clears the frame registers other than desc and the page buffer state, and frees the output pin
   assign link_rst_b = rst_b & ~chip_select_n;
   assign rx_byte = {rx_sh, serial_in};
   assign byte_done = (bit_cnt == BIT_LAST);
   assign next_addr = {addr[HOST_AW-9:0], rx_byte};
   assign busy_l = status_l[STAT_BUSY_BIT];

   // Input bits taken on rising edges, MSB first
   always_ff @(posedge spi_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         bit_cnt <= 3'h0;
         rx_sh <= 7'h00;
      end else begin
         bit_cnt <= bit_cnt + 3'h1;
         rx_sh <= rx_byte[6:0];
      end
   end

   // Byte position within the frame
   always_ff @(posedge spi_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         byte_cnt <= BYTE_OPCODE;
      end else if (byte_done && byte_cnt != BYTE_SAT) begin
         byte_cnt <= byte_cnt + 3'h1;
      end
   end

   // Opcode and 24-bit address capture
   always_ff @(posedge spi_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         opcode <= 8'h00;
         addr <= '0;
      end else if (byte_done) begin
         if (byte_cnt == BYTE_OPCODE) begin
            opcode <= rx_byte;
         end else if (byte_cnt <= BYTE_ADDR_LAST) begin
            addr <= next_addr;
         end
      end
   end

   // Command handed to the core; ok only while frame sits on the
   // right byte boundary, so any extra bit cancels the command
   always_ff @(posedge spi_clk or negedge rst_b) begin
      if (!rst_b) begin
         desc <= '0;
      end else begin
         desc.ok <= 1'b0;
         if (byte_done) begin
            if (byte_cnt == BYTE_OPCODE && rx_byte == WRITE_ENABLE_CMD) begin
               desc.ok <= 1'b1;
               desc.opcode <= rx_byte;
            end else if (byte_cnt == BYTE_ADDR_LAST &&
                         (opcode == SECTOR_ERASE_CMD ||
                          opcode == BLOCK_ERASE_CMD)) begin
               desc.ok <= 1'b1;
               desc.opcode <= opcode;
               desc.addr <= next_addr;
            end else if (byte_cnt >= BYTE_DATA && opcode == PAGE_PROGRAM_CMD) begin
               desc.ok <= 1'b1;
               desc.opcode <= opcode;
               desc.addr <= addr;
            end
         end
      end
   end

   // Choose what the output shows; array reads refused while busy
   always_ff @(posedge spi_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         tx_mode <= TX_NONE;
         tx_start <= '0;
      end else if (byte_done) begin
         if (byte_cnt == BYTE_OPCODE && rx_byte == READ_STATUS_CMD) begin
            tx_mode <= TX_STATUS;
         end else if (byte_cnt == BYTE_ADDR_LAST && opcode == READ_CMD &&
                      !busy_l) begin
            tx_mode <= TX_MEM;
            tx_start <= next_addr[ADDR_W-1:0];
         end else if (byte_cnt == BYTE_DUMMY && opcode == FAST_READ_CMD &&
                      !busy_l) begin
            tx_mode <= TX_MEM;
            tx_start <= addr[ADDR_W-1:0];
         end
      end
   end

   // Page buffer bookkeeping; kept across deselect for the core
   assign pb_we = byte_done && byte_cnt >= BYTE_DATA && pb_armed &&
                  opcode == PAGE_PROGRAM_CMD;
   always_ff @(posedge spi_clk or negedge rst_b) begin
      if (!rst_b) begin
         pb_valid <= '0;
         pb_ptr <= '0;
         pb_armed <= 1'b0;
      end else if (byte_done) begin
         if (byte_cnt == BYTE_OPCODE) begin
            // Never touch the buffer while the core drains it
            pb_armed <= (rx_byte == PAGE_PROGRAM_CMD) && !busy_l;
            if (rx_byte == PAGE_PROGRAM_CMD && !busy_l) begin
               pb_valid <= '0;
            end
         end else if (byte_cnt == BYTE_ADDR_LAST) begin
            pb_ptr <= rx_byte; // Page offset of the first data byte
         end else if (pb_we) begin
            pb_valid[pb_ptr] <= 1'b1;
            pb_ptr <= pb_ptr + 8'h01;
         end
      end
   end

   // Buffer data; a later byte at an offset overwrites an earlier one
   always_ff @(posedge spi_clk) begin
      if (pb_we) begin
         pb_data[pb_ptr] <= rx_byte;
      end
   end

   // Byte to start shifting when a new byte begins
   always_comb begin
      tx_fetch = tx_started ? tx_addr : tx_start;
      if (tx_mode == TX_STATUS) begin
         tx_byte = status_l;
      end else begin
         tx_byte = mem[tx_fetch];
      end
   end

   // Output shifter on falling edges, MSB first
   always_ff @(negedge spi_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         serial_out <= 1'b0;
         serial_out_en <= 1'b0;
         tx_sh <= 7'h00;
         tx_idx <= 3'h0;
         tx_started <= 1'b0;
         tx_addr <= '0;
      end else if (tx_mode != TX_NONE) begin
         serial_out_en <= 1'b1;
         tx_idx <= tx_idx + 3'h1;
         if (tx_idx == 3'h0) begin
            serial_out <= tx_byte[7];
            tx_sh <= tx_byte[6:0];
            tx_started <= 1'b1;
            tx_addr <= tx_fetch + ADDR_W'(1); // Wraps at the top
         end else begin
            serial_out <= tx_sh[6];
            tx_sh <= {tx_sh[5:0], 1'b0};
         end
      end
   end

   // Status bits reach the link through three flops; a bit moves once
   // the second and third agree, so a half-settled bit is not shown
   always_ff @(posedge spi_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_f1 <= 8'h00;
         st_f2 <= 8'h00;
         st_f3 <= 8'h00;
         status_l <= 8'h00;
      end else begin
         st_f1 <= status_word;
         st_f2 <= st_f1;
         st_f3 <= st_f2;
         for (int i = 0; i < 8; i++) begin
            if (st_f2[i] == st_f3[i]) begin
               status_l[i] <= st_f3[i];
            end
         end
      end
   end

   // Deselect seen by the core, filtered the same way
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cs_f <= CS_SYNC_RESET;
         cs_lvl <= 1'b1;
      end else begin
         cs_f <= {cs_f[1:0], chip_select_n};
         if (cs_f[1] == cs_f[2]) begin
            cs_lvl <= cs_f[2];
         end
      end
   end
   assign cs_rise = (cs_f[1] == cs_f[2]) && cs_f[2] && !cs_lvl;

   // Target regions of the frame just ended
   assign d_addr = desc.addr[ADDR_W-1:0];
   assign page_last = d_addr | ADDR_W'(PAGE_BYTES - 1);
   assign sector_last = d_addr | ADDR_W'((1 << SECTOR_AW) - 1);
   assign block_last = d_addr | ADDR_W'((1 << BLOCK_AW) - 1);

   // Start decisions, all taken at deselect
   always_comb begin
      start_prog = 1'b0;
      start_sector = 1'b0;
      start_block = 1'b0;
      if (cs_rise && desc.ok && write_latch && state == ST_IDLE) begin
         if (desc.opcode == PAGE_PROGRAM_CMD) begin
            start_prog = !is_protected(block_protect, page_last);
         end else if (desc.opcode == SECTOR_ERASE_CMD) begin
            start_sector = !is_protected(block_protect, sector_last);
         end else if (desc.opcode == BLOCK_ERASE_CMD) begin
            start_block = !is_protected(block_protect, block_last);
         end
      end
      start_any = start_prog | start_sector | start_block;
   end

   // Sequencer next state: walk the target, then hold the timer
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start_prog) begin
               next_state = ST_PROGRAM;
            end else if (start_sector || start_block) begin
               next_state = ST_ERASE;
            end
         end
         ST_PROGRAM: begin
            if (wp == wlast) begin
               next_state = ST_HOLD;
            end
         end
         ST_ERASE: begin
            if (wp == wlast) begin
               next_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (timer <= 32'h1) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Walk pointer and region end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wp <= '0;
         wlast <= '0;
      end else if (start_prog) begin
         wp <= page_last & ~ADDR_W'(PAGE_BYTES - 1);
         wlast <= page_last;
      end else if (start_sector) begin
         wp <= sector_last & ~ADDR_W'((1 << SECTOR_AW) - 1);
         wlast <= sector_last;
      end else if (start_block) begin
         wp <= block_last & ~ADDR_W'((1 << BLOCK_AW) - 1);
         wlast <= block_last;
      end else if ((state == ST_PROGRAM || state == ST_ERASE) && wp != wlast) begin
         wp <= wp + ADDR_W'(1);
      end
   end

   // Duration timer, loaded at the start with the configured count
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         timer <= 32'h0;
      end else if (start_prog) begin
         timer <= 32'(PROG_CYCLES);
      end else if (start_sector) begin
         timer <= 32'(SECTOR_ERASE_CYCLES);
      end else if (start_block) begin
         timer <= 32'(BLOCK_ERASE_CYCLES);
      end else if (state == ST_HOLD && timer != 32'h0) begin
         timer <= timer - 32'h1;
      end
   end

   // Array write: only received bytes programmed, erase fills FFh
   always_comb begin
      mem_we = 1'b0;
      mem_wdata = ERASED_BYTE;
      if (state == ST_PROGRAM) begin
         mem_we = pb_valid[wp[PAGE_AW-1:0]];
         mem_wdata = pb_data[wp[PAGE_AW-1:0]];
      end else if (state == ST_ERASE) begin
         mem_we = 1'b1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (mem_we) begin
         mem[wp] <= mem_wdata;
      end
   end

   // Busy from the start edge until the timer runs out
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_flag <= 1'b0;
      end else begin
         busy_flag <= (next_state != ST_IDLE);
      end
   end

   // Latch: set by write enable, dropped as each cycle begins, which
   // is always ahead of busy falling
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         write_latch <= 1'b0;
      end else if (cs_rise && desc.ok && desc.opcode == WRITE_ENABLE_CMD &&
                   state == ST_IDLE) begin
         write_latch <= 1'b1;
      end else if (start_any) begin
         write_latch <= 1'b0;
      end
   end

   // Protect field: all ones after reset, loadable when idle
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         block_protect <= BP_RESET;
      end else if (block_protect_wr && state == ST_IDLE && !busy_flag) begin
         block_protect <= block_protect_val;
      end
   end

   // Status byte image; upper bits read as zero
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_word <= 8'h00;
      end else begin
         status_word <= 8'h00;
         status_word[STAT_BUSY_BIT] <= busy_flag;
         status_word[STAT_LATCH_BIT] <= write_latch;
         status_word[STAT_BP_LSB +: BP_W] <= block_protect;
      end
   end
endmodule

// File: sfs_top_assertions.sv
// Port checker for the serial flash sequencer.
// Bound into sfs_top; sees only its ports, all sampled on sys_clk.
`timescale 1ns/1ps
module sfs_chk #(
   parameter int PROG_CYCLES = 4,
   parameter int BLOCK_ERASE_CYCLES = 4
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic chip_select_n,
   input wire logic block_protect_wr,
   input wire logic [sfs_pkg::BP_W-1:0] block_protect_val,
   input wire logic serial_out,
   input wire logic serial_out_en,
   input wire logic busy_flag,
   input wire logic write_latch,
   input wire logic [sfs_pkg::BP_W-1:0] block_protect
);
   import sfs_pkg::*;
   int busy_cnt; // Edges spent busy so far
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Length of the running timed cycle; bounds both ends of it
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= busy_flag ? busy_cnt + 1 : 0;
      end
   end
   // Steps of a timed cycle and of a protect load
   sequence s_start;
      $rose(busy_flag);
   endsequence
   sequence s_end;
      $fell(busy_flag);
   endsequence
   sequence s_load;
      block_protect_wr && !busy_flag;
   endsequence
   property p_cs_release;
      chip_select_n |-> !serial_out_en;
   endproperty
   property p_out_quiet;
      !serial_out_en |-> !serial_out;
   endproperty
   property p_busy_start;
      s_start |-> $past(chip_select_n, 3);
   endproperty
   property p_needs_latch;
      s_start |-> $past(write_latch);
   endproperty
   property p_latch_drop;
      s_start |-> !write_latch;
   endproperty
   property p_latch_end;
      s_end |-> !write_latch;
   endproperty
   property p_busy_min;
      s_end |-> busy_cnt >= 255 + PROG_CYCLES;
   endproperty
   property p_busy_max;
      busy_flag |-> busy_cnt < 65540 + BLOCK_ERASE_CYCLES;
   endproperty
   property p_bp_load;
      s_load |=> block_protect == $past(block_protect_val);
   endproperty
   property p_bp_hold;
      busy_flag && $past(busy_flag) |-> $stable(block_protect);
   endproperty
   // Status reads still drive the pin while busy, so the check is that
   // a frame opened during the cycle cannot cut the cycle short
   property p_read_blocked;
      !chip_select_n && busy_flag && busy_cnt < 255 + PROG_CYCLES |=> busy_flag;
   endproperty
   a_cs_release: assert property (p_cs_release)
      else $error("output driven while deselected");
   a_out_quiet: assert property (p_out_quiet)
      else $error("data line not quiet");
   a_busy_start: assert property (p_busy_start)
      else $error("busy rose without deselect");
   a_needs_latch: assert property (p_needs_latch)
      else $error("timed cycle without write latch");
   a_latch_drop: assert property (p_latch_drop)
      else $error("write latch kept at cycle start");
   a_latch_end: assert property (p_latch_end)
      else $error("write latch set as busy ends");
   a_busy_min: assert property (p_busy_min)
      else $error("timed cycle too short");
   a_busy_max: assert property (p_busy_max)
      else $error("timed cycle too long");
   a_bp_load: assert property (p_bp_load)
      else $error("protect field not loaded");
   a_bp_hold: assert property (p_bp_hold)
      else $error("protect field changed while busy");
   a_read_blocked: assert property (p_read_blocked)
      else $error("timed cycle cut by a frame");
endmodule
bind sfs_top sfs_chk #(.PROG_CYCLES(PROG_CYCLES), .BLOCK_ERASE_CYCLES(BLOCK_ERASE_CYCLES)) u_chk (
   .sys_clk(sys_clk), .rst_b(rst_b), .chip_select_n(chip_select_n),
   .block_protect_wr(block_protect_wr), .block_protect_val(block_protect_val),
   .serial_out(serial_out), .serial_out_en(serial_out_en), .busy_flag(busy_flag),
   .write_latch(write_latch), .block_protect(block_protect));

// File: sfs_host.sv
// Host link controller model: select, 48 ns serial clock and data.
// Clock stands still between frames; released data line toggles.
`timescale 1ns/1ps
module sfs_host (
   output logic spi_clk,
   output logic chip_select_n,
   output logic serial_in,
   input wire logic serial_out
);
   // Idle link at time zero
   initial begin
      spi_clk = 1'b0;
      chip_select_n = 1'b1;
      serial_in = 1'b0;
   end
   // Select stays low for the whole frame
   task automatic open_frame();
      chip_select_n = 1'b0;
      #24;
   endtask
   // Bits MSB first, reply taken on the rising edge
   task automatic shift(input logic [7:0] v, input int n, output logic [7:0] r);
      r = 8'h00;
      for (int i = 0; i < n; i++) begin
         serial_in = v[7-i];
         #24;
         spi_clk = 1'b1;
         r = {r[6:0], serial_out};
         #24;
         spi_clk = 1'b0;
      end
   endtask
   // Gap kept long so the core sees the deselect before the next frame
   task automatic close_frame();
      #24;
      chip_select_n = 1'b1;
      serial_in = ~serial_in;
      #400;
   endtask
endmodule

// File: tb_serial_flash_read_program_erase.sv
// Self-checking bench for the flash sequencer against an array model.
// Core inputs change on falling sys_clk; link traffic from sfs_host.
`timescale 1ns/1ps
module tb_serial_flash_read_program_erase;
   import sfs_pkg::*;
   localparam int AW = 17; // Two 64 KB blocks keep the run short
   localparam int SZ = 1 << AW;
   logic sys_clk, rst_b, spi_clk, chip_select_n, serial_in, bp_wr;
   logic serial_out, serial_out_en, busy_flag, write_latch;
   logic [BP_W-1:0] bp_val, block_protect;
   logic [7:0] mem [SZ]; // Expected array image
   logic [7:0] r; // Last reply byte
   int bp_m; // Expected protect field
   int fail_count = 0;
   int cmp_count = 0;
   // Core clock, 40 ns
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   sfs_top #(.ADDR_W(AW), .PROG_CYCLES(4), .SECTOR_ERASE_CYCLES(6), .BLOCK_ERASE_CYCLES(8)) u_dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .spi_clk(spi_clk), .chip_select_n(chip_select_n),
      .serial_in(serial_in), .block_protect_wr(bp_wr), .block_protect_val(bp_val),
      .serial_out(serial_out), .serial_out_en(serial_out_en), .busy_flag(busy_flag),
      .write_latch(write_latch), .block_protect(block_protect));
   sfs_host u_host (.spi_clk(spi_clk), .chip_select_n(chip_select_n), .serial_in(serial_in),
      .serial_out(serial_out));
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // Protected when nonzero; field 1 covers the upper block only
   function automatic bit prot(input int a);
      return bp_m == 0 ? 1'b0 : (bp_m == 1 ? a[16] : 1'b1);
   endfunction
   // Opcode then three address bytes
   task automatic cmd(input logic [7:0] op, input int a);
      u_host.open_frame();
      u_host.shift(op, 8, r);
      for (int i = 2; i >= 0; i--) u_host.shift(8'(a >> (8 * i)), 8, r);
   endtask
   task automatic latch_on();
      u_host.open_frame();
      u_host.shift(WRITE_ENABLE_CMD, 8, r);
      u_host.close_frame();
      @(negedge sys_clk);
      chk(write_latch, 1'b1);
   endtask
   // Busy only if accepted; then bounded wait for the end
   task automatic settle(input bit go);
      repeat (2) @(negedge sys_clk);
      chk(busy_flag, go);
      for (int n = 0; n < 70000 && busy_flag !== 1'b0; n++) @(negedge sys_clk);
      chk({busy_flag, write_latch & go}, 2'b00);
   endtask
   // While busy: status readable, array read refused
   task automatic probe();
      u_host.open_frame();
      u_host.shift(READ_STATUS_CMD, 8, r);
      u_host.shift(8'h00, 8, r);
      chk(r, {3'h0, 3'(bp_m), 2'b01});
      u_host.close_frame();
      cmd(READ_CMD, 0);
      u_host.shift(8'h00, 8, r);
      #1;
      chk(serial_out_en, 1'b0);
      u_host.close_frame();
   endtask
   // Program n random bytes; cut leaves a partial last byte
   task automatic prog(input int a, input int n, input bit cut, input bit en);
      logic [7:0] d;
      bit go;
      go = en && !cut && !prot(a);
      if (en) latch_on();
      cmd(PAGE_PROGRAM_CMD, a);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         u_host.shift(d, 8, r);
         if (go) mem[{a[16:8], 8'(a + i)}] = d;
      end
      if (cut) u_host.shift(8'hA5, 3, r);
      u_host.close_frame();
      settle(go);
   endtask
   task automatic erase(input logic [7:0] op, input int a, input bit cut);
      int w;
      bit go;
      w = (op == SECTOR_ERASE_CMD) ? 4096 : 65536;
      go = !cut && !prot(a);
      latch_on();
      cmd(op, a);
      if (cut) u_host.shift(8'h00, 1, r);
      u_host.close_frame();
      if (go) begin
         for (int i = 0; i < w; i++) mem[(a / w) * w + i] = ERASED_BYTE;
         probe();
      end
      settle(go);
   endtask
   // Read n bytes, then deselect three bits into the next one
   task automatic rd(input logic [7:0] op, input int a, input int n);
      cmd(op, a);
      if (op == FAST_READ_CMD) u_host.shift(8'h00, 8, r);
      for (int i = 0; i < n; i++) begin
         u_host.shift(8'h00, 8, r);
         chk(r, mem[(a + i) % SZ]);
      end
      u_host.shift(8'h00, 3, r);
      u_host.close_frame();
      chk(serial_out_en, 1'b0);
   endtask
   task automatic set_bp(input int v);
      @(negedge sys_clk);
      bp_val = 3'(v);
      bp_wr = 1'b1;
      @(negedge sys_clk);
      bp_wr = 1'b0;
      bp_m = v;
      @(negedge sys_clk);
      chk(block_protect, 3'(v));
   endtask
   // Main sequence
   initial begin
      rst_b = 1'b0;
      bp_wr = 1'b0;
      bp_val = 3'h0;
      bp_m = 7;
      void'($urandom(87677));
      repeat (10) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk({busy_flag, write_latch, block_protect}, 5'h07);
      prog(32'h00100, 4, 1'b0, 1'b1);
      set_bp(0);
      erase(BLOCK_ERASE_CMD, $urandom_range(16'hFFFF), 1'b0);
      erase(SECTOR_ERASE_CMD, 32'h1F000 + $urandom_range(12'hFFF), 1'b0);
      prog(32'h00200, 4, 1'b0, 1'b0);
      prog(32'h012F0, 20, 1'b0, 1'b1);
      prog(32'h03405, 260, 1'b0, 1'b1);
      prog(32'h01200, 8, 1'b1, 1'b1);
      erase(SECTOR_ERASE_CMD, 32'h01000, 1'b1);
      prog(32'h1FFFC, 8, 1'b0, 1'b1);
      prog(32'h00000, 4, 1'b0, 1'b1);
      set_bp(1);
      prog(32'h1F100, 4, 1'b0, 1'b1);
      erase(SECTOR_ERASE_CMD, 32'h1F000, 1'b0);
      erase(BLOCK_ERASE_CMD, 32'h10000, 1'b0);
      prog(32'h00500, 16, 1'b0, 1'b1);
      set_bp(0);
      rd(READ_CMD, 32'h1FFFC, 8);
      rd(FAST_READ_CMD, 32'h01200, 256);
      rd(READ_CMD, 32'h03400, 256);
      rd(FAST_READ_CMD, 32'h004F8, 32);
      test_done();
   end
   // Watchdog, about a fifth past the expected run length
   initial begin
      #3900000;
      fail_count++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      test_done();
   end
endmodule
